// *** rtl/pin_mux_pkg.sv ***
// Constants, types and port availability table for the pin output source selector
`default_nettype none
package pin_mux_pkg;
  localparam int          PINS_PER_PORT = 8;
  localparam int          NUM_PORTS     = 3;
  localparam int          NUM_PINS      = PINS_PER_PORT * NUM_PORTS;
  localparam int          SEL_W         = 6;
  localparam int          NUM_SRC       = 51;
  localparam int          ADDR_W        = 8;
  localparam int          LOCK_BIT      = 0;
  localparam logic [7:0]  SEL_OFFSET    = 8'h00;
  localparam logic [7:0]  LOCK_OFFSET   = 8'h60;
  localparam logic [5:0]  SEL_RESET     = 6'h00;
  localparam logic        LOCK_RESET    = 1'b0;
  localparam logic [5:0]  CODE_LATCH    = 6'h00;
  localparam logic [5:0]  CODE_CAPTURE_ONE = 6'h09;
  localparam logic [5:0]  CODE_LAST     = 6'h32;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } wr_req_t;

  // Ports that may carry each code, bit 0 = port A, bit 2 = port C; zero for reserved codes
  function automatic logic [2:0] port_avail(input logic [5:0] code);
    logic [2:0] m;
    m = 3'h0;
    case (code)
      6'h00: m = 3'h7;
      6'h01, 6'h02, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h1C, 6'h1D, 6'h20,
      6'h26, 6'h28, 6'h2E, 6'h2F, 6'h30, 6'h31, 6'h32: m = 3'h5;
      6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C,
      6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h1E, 6'h1F, 6'h21, 6'h22,
      6'h23, 6'h24, 6'h25, 6'h27, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D: m = 3'h6;
      default: m = 3'h0;
    endcase
    return m;
  endfunction
endpackage
`default_nettype wire

// *** rtl/pin_output_source_mux.sv ***
// Per-pin output source selector with AXI4-Lite register access
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module pin_output_source_mux
  import pin_mux_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 warm_reset,
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [NUM_PINS-1:0]  port_output_latch,
  input  wire logic [NUM_SRC-1:1]   source_in,
  output logic [NUM_PINS-1:0]       pin_out
);

  wr_req_t                 wr_reg;
  wr_req_t                 wr_next;
  logic                    aw_held_reg;
  logic                    aw_held_next;
  logic                    w_held_reg;
  logic                    w_held_next;
  logic                    bvalid_reg;
  logic                    bvalid_next;
  logic [1:0]              bresp_reg;
  logic [1:0]              bresp_next;
  logic                    rvalid_reg;
  logic                    rvalid_next;
  logic [31:0]             rdata_reg;
  logic [31:0]             rdata_next;
  logic [1:0]              rresp_reg;
  logic [1:0]              rresp_next;
  logic [SEL_W-1:0]        sel_reg  [NUM_PINS];
  logic [SEL_W-1:0]        sel_next [NUM_PINS];
  logic                    lock_reg;
  logic                    lock_next;
  logic [NUM_PINS-1:0]     pin_reg;
  logic [NUM_PINS-1:0]     pin_next;
  wr_req_t                 cur;
  logic                    aw_have;
  logic                    w_have;
  logic                    do_write;
  logic [5:0]              wr_idx;
  logic [5:0]              rd_idx;
  logic                    sel_wr;

  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready  = !w_held_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;
  assign pin_out = pin_reg;

  // Address and data may arrive in either order; a held half waits for the other
  always_comb begin
    cur.addr     = aw_held_reg ? wr_reg.addr : awaddr;
    cur.data     = w_held_reg ? wr_reg.data : wdata;
    cur.strb     = w_held_reg ? wr_reg.strb : wstrb;
    aw_have      = aw_held_reg || awvalid;
    w_have       = w_held_reg || wvalid;
    do_write     = aw_have && w_have && !bvalid_reg;
    wr_idx       = cur.addr[7:2];
    rd_idx       = araddr[7:2];
    sel_wr       = cur.addr < LOCK_OFFSET;
    wr_next      = cur;
    aw_held_next = (aw_held_reg || (awvalid && awready)) && !do_write;
    w_held_next  = (w_held_reg || (wvalid && wready)) && !do_write;
    bvalid_next  = bvalid_reg && !bready;
    bresp_next   = bresp_reg;
    if (do_write) begin
      bvalid_next = 1'b1;
      bresp_next  = (sel_wr || wr_idx == LOCK_OFFSET[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_comb begin
    rvalid_next = rvalid_reg && !rready;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = RDATA_ZERO;
      if (araddr < LOCK_OFFSET) begin
        rdata_next[SEL_W-1:0] = sel_reg[rd_idx[4:0]];
      end else if (rd_idx == LOCK_OFFSET[7:2]) begin
        rdata_next[LOCK_BIT] = lock_reg;
      end else begin
        rresp_next = RESP_SLVERR;
      end
    end
  end

  // Lock clears on every reset; only a warm_reset in the same cycle blocks a write to it, so software can unlock
  always_comb begin
    lock_next = lock_reg;
    if (warm_reset) begin
      lock_next = LOCK_RESET;
    end else if (do_write && wr_idx == LOCK_OFFSET[7:2] && cur.strb[0]) begin
      lock_next = cur.data[LOCK_BIT];
    end
  end

  // Selections ignore the warm reset: only aresetn (power-on or brown-out) clears them
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      sel_next[i] = sel_reg[i];
    end
    if (do_write && sel_wr && !lock_reg && cur.strb[0]) begin
      sel_next[wr_idx[4:0]] = cur.data[SEL_W-1:0];
    end
  end

  // Pins sample the next selection so a write shows one cycle later, not two
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    always_comb begin
      logic [2:0] avail;
      avail = port_avail(sel_next[p]);
      pin_next[p] = 1'b0;
      if (sel_next[p] == CODE_LATCH) begin
        pin_next[p] = port_output_latch[p];
      end else if (sel_next[p] <= CODE_LAST && avail[p / PINS_PER_PORT]) begin
        pin_next[p] = source_in[sel_next[p]];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_reg      <= '0;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= RDATA_ZERO;
      rresp_reg   <= RESP_OKAY;
      lock_reg    <= LOCK_RESET;
      pin_reg     <= '0;
      for (int i = 0; i < NUM_PINS; i++) begin
        sel_reg[i] <= SEL_RESET;
      end
    end else begin
      wr_reg      <= wr_next;
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      lock_reg    <= lock_next;
      pin_reg     <= pin_next;
      for (int i = 0; i < NUM_PINS; i++) begin
        sel_reg[i] <= sel_next[i];
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  upper_bits_zero_a: assert property (rvalid |-> rdata[31:SEL_W] == '0)
    else $error("select readback has upper bits set");
  reset_clears_a: assert property (!$past(aresetn) |-> sel_reg[3] == SEL_RESET)
    else $error("selection not cleared by power reset");
  warm_keeps_a: assert property (warm_reset && !do_write |=> $stable(sel_reg[8]))
    else $error("selection changed across warm reset");
  lock_blocks_a: assert property (lock_reg && do_write && wr_idx == 6'h08 |=> $stable(sel_reg[8]))
    else $error("locked selection was overwritten");
  write_lands_a: assert property (!lock_reg && do_write && wr_idx == 6'h10 && cur.strb[0]
                                  |=> sel_reg[16] == $past(cur.data[SEL_W-1:0]))
    else $error("write did not reach selection");
  latch_follows_a: assert property ($past(aresetn) && sel_reg[0] == CODE_LATCH
                                    |-> pin_out[0] == $past(port_output_latch[0]))
    else $error("latch not routed to pin");
  source_routes_a: assert property ($past(aresetn) && sel_reg[8] == CODE_CAPTURE_ONE
                                    |-> pin_out[8] == $past(source_in[CODE_CAPTURE_ONE]))
    else $error("capture source not routed to port B pin");
  unlisted_low_a: assert property (sel_reg[0] == CODE_CAPTURE_ONE |-> !pin_out[0])
    else $error("source reached a port it is not listed for");
  reserved_low_a: assert property (sel_reg[16] > CODE_LAST || sel_reg[16] == 6'h11 |-> !pin_out[16])
    else $error("reserved code drove the pin");
  bresp_holds_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  locked_write_c: cover property (lock_reg && do_write && sel_wr);
  warm_reset_c: cover property (warm_reset && sel_reg[0] != SEL_RESET);
  source_path_c: cover property (sel_reg[8] == CODE_CAPTURE_ONE && pin_out[8]);

endmodule
`default_nettype wire

// *** rtl/pin_mux_unused_guard.sv ***
// Holds no logic; the selector lives in the main design file and its port table in the package

// *** testbench/periph_model.sv ***
// Peripheral side model: drives the source numbered hot high when hot is 1 to 50, all others low
`default_nettype none
module periph_model
  import pin_mux_pkg::*;
(
  input  wire logic [5:0]         hot,
  output logic      [NUM_SRC-1:1] source_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-hot so that a pin routed to the wrong source reads low
  always_comb begin
    source_in = '0;
    for (int i = 1; i < NUM_SRC; i++) begin
      source_in[i] = (hot == 6'(i));
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Register and routing tests for the pin output source selector
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pin_mux_pkg::*;
  logic aclk, aresetn, warm_reset;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [NUM_PINS-1:0] latch, pin_out;
  logic [NUM_SRC-1:1] source_in;
  logic [5:0] hot;
  int err_total, check_count;

  pin_output_source_mux pin_output_source_mux_inst (.aclk(aclk), .aresetn(aresetn),
    .warm_reset(warm_reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .port_output_latch(latch), .source_in(source_in), .pin_out(pin_out));
  periph_model periph_model_inst (.hot(hot), .source_in(source_in));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Both halves offered together; each released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    // Idle edge so a following call never reassigns bready in this time step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic pin_is(input int p, input logic e);
    repeat (2) @(posedge aclk);
    chk({31'h0, pin_out[p]}, {31'h0, e});
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  initial begin
    err_total = 0; check_count = 0;
    warm_reset = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    wdata = 32'h0000_0000; wstrb = 4'h0; hot = 6'h00; latch = '1;
    // Reset is low for the first two edges
    do_reset();
    rd(8'h14); chk(rd_v, 32'h0000_0000);
    rd(LOCK_OFFSET); chk(rd_v, 32'h0000_0000);
    wr(8'h00, 32'hFFFF_FFFF); chk({30'h0, resp}, {30'h0, RESP_OKAY});
    rd(8'h00); chk(rd_v, 32'h0000_003F);
    hot <= 6'h3F; pin_is(0, 1'b0);
    // Every code on a port C pin; reserved codes must stay low
    for (int c = 0; c < 64; c++) begin
      wr(8'h40, 32'(c));
      hot <= 6'(c);
      pin_is(16, c <= 16 || (c >= 19 && c <= 24) || (c >= 28 && c <= 50));
    end
    wr(8'h20, 32'h0000_0009);
    wr(8'h00, 32'h0000_0009);
    hot <= 6'h09;
    pin_is(8, 1'b1);
    pin_is(0, 1'b0);
    wr(8'h20, 32'h0000_0001); hot <= 6'h01; pin_is(8, 1'b0);
    latch <= 24'h00_0100; wr(8'h20, 32'h0000_0000); pin_is(8, 1'b1);
    pin_is(9, 1'b0);
    wr(8'h20, 32'h0000_0009);
    wr(LOCK_OFFSET, 32'h0000_0001);
    rd(LOCK_OFFSET); chk(rd_v, 32'h0000_0001);
    wr(8'h20, 32'h0000_0005); rd(8'h20); chk(rd_v, 32'h0000_0009);
    warm_reset <= 1'b1; @(posedge aclk); warm_reset <= 1'b0; @(posedge aclk);
    rd(LOCK_OFFSET); chk(rd_v, 32'h0000_0000);
    rd(8'h20); chk(rd_v, 32'h0000_0009);
    wr(8'h20, 32'h0000_0005); rd(8'h20); chk(rd_v, 32'h0000_0005);
    rd(8'h64); chk({rd_v[29:0], resp}, {30'h0, RESP_SLVERR});
    do_reset();
    rd(8'h20); chk(rd_v, 32'h0000_0000);
    end_of_test();
  end

  // Tests need about 400 cycles; a hung handshake ends here
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
